/* File: rtl/pcstk_defines.svh */
`ifndef PCSTK_DEFINES_SVH
`define PCSTK_DEFINES_SVH

`define PC_WIDTH         21
`define PC_STEP          21'h000002
`define PC_RESET         21'h000000
`define SP_WIDTH         5
`define STACK_DEPTH      31
`define SP_EMPTY         5'h00
`define SP_FULL          5'h1f
`define SP_ONE           5'h01
`define UPPER_BITS       5
`define ADDR_OFFSET_LO   2
`define ADDR_WIDTH       6
`define OFS_PC_LOW       6'h00
`define OFS_PC_HIGH_LAT  6'h04
`define OFS_PC_UPPER_LAT 6'h08
`define OFS_STACK_PTR    6'h0c
`define OFS_TOP_LOW      6'h10
`define OFS_TOP_HIGH     6'h14
`define OFS_TOP_UPPER    6'h18
`define OFS_STATUS       6'h1c
`define OFS_PC_FULL      6'h20
`define BIT_FULL         0
`define BIT_OVERFLOW     1
`define BIT_UNDERFLOW    2
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* File: rtl/pcstk_pkg.sv */
package pcstk_pkg;

    // Sequencing requests from the execution and interrupt logic
    typedef enum logic [2:0] {
        OP_NONE   = 3'b000,
        OP_STEP   = 3'b001,
        OP_LOAD   = 3'b010,
        OP_CALL   = 3'b011,
        OP_RETURN = 3'b100,
        OP_IRQ    = 3'b101
    } pc_op_type;

    typedef struct packed {
        pc_op_type   op;
        logic [20:0] target;
    } pc_req_type;

    typedef struct packed {
        logic [20:0] pc;
        logic [4:0]  sp;
        logic        full;
        logic        overflow;
        logic        underflow;
    } pc_state_type;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RRESP = 2'b10
    } bus_state_type;

endpackage : pcstk_pkg

/* File: rtl/return_stack_ram.sv */
`timescale 1ns/1ps
`include "pcstk_defines.svh"

module return_stack_ram #(
    parameter int DEPTH = `STACK_DEPTH,
    parameter int WIDTH = `PC_WIDTH,
    parameter int AW    = `SP_WIDTH
) (
    input  wire logic             aclk,    // Core clock
    input  wire logic             we,      // Write strobe
    input  wire logic [AW-1:0]    waddr,   // Write entry, 1..DEPTH
    input  wire logic [WIDTH-1:0] wdata,   // Write value
    input  wire logic [AW-1:0]    raddr,   // Read entry, 1..DEPTH
    output logic      [WIDTH-1:0] rdata    // Read value, 0 at entry 0
);
    // Entry 0 has no storage; index 0 of the array is entry 1
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge aclk) begin
        if (we && waddr != '0) begin
            mem_r[waddr - AW'(1)] <= wdata;
        end
    end

    always_comb begin
        rdata = '0;
        if (raddr != '0) begin
            rdata = mem_r[raddr - AW'(1)];
        end
    end

endmodule : return_stack_ram

/* File: rtl/axil_decode.sv */
`timescale 1ns/1ps
`include "pcstk_defines.svh"

module axil_decode (
    input  wire logic [`ADDR_WIDTH-1:0] addr,   // Byte address
    output logic                        hit,    // Mapped register
    output logic [3:0]                  index   // Register index
);
    always_comb begin
        index = addr[`ADDR_WIDTH-1:`ADDR_OFFSET_LO];
        hit   = (addr[`ADDR_OFFSET_LO-1:0] == 2'h0) &&
                (addr <= `OFS_PC_FULL);
    end

endmodule : axil_decode

/* File: rtl/program_counter_return_stack.sv */
`timescale 1ns/1ps
`include "pcstk_defines.svh"

// Summary of operation
// - 21-bit counter in low, high, upper bytes
// - Low byte readable and writable by software
// - High byte reached through holding latch; full counter view reads it directly
// - Upper byte reached through holding latch; full counter view reads it directly
// - Low byte write loads both latches into counter unless a core request is in the same cycle
// - Low byte read copies counter into latches
// - Counter bit zero always zero
// - Sequential execution adds two
// - Calls, gotos, branches load target directly
// - Up to 31 nested calls and interrupts
// - Push on call or interrupt acknowledge
// - Pop on any return instruction
// - Calls and returns keep holding latches
// - 31 by 21 storage, 5-bit pointer
// - Software reads and writes pointer and top
// - Push increments pointer, then writes entry
// - Pop reads entry, then decrements pointer
// - Reset clears pointer; zero has no storage
// - Full, overflow and underflow status flags
// - Top entry shown as three bytes
module program_counter_return_stack
    import pcstk_pkg::*;
(
    input  wire logic                       aclk,     // Core clock
    input  wire logic                       aresetn,  // Sync reset, low
    input  wire pcstk_pkg::pc_req_type      pc_req,   // Sequencing request
    output pcstk_pkg::pc_state_type         pc_state, // Counter and stack
    input  wire logic [`ADDR_WIDTH-1:0]     awaddr,   // AXI write address
    input  wire logic [2:0]                 awprot,   // Unused
    input  wire logic                       awvalid,  // AXI
    output logic                            awready,  // AXI
    input  wire logic [31:0]                wdata,    // AXI write data
    input  wire logic [3:0]                 wstrb,    // AXI byte enables
    input  wire logic                       wvalid,   // AXI
    output logic                            wready,   // AXI
    output logic [1:0]                      bresp,    // AXI
    output logic                            bvalid,   // AXI
    input  wire logic                       bready,   // AXI
    input  wire logic [`ADDR_WIDTH-1:0]     araddr,   // AXI read address
    input  wire logic [2:0]                 arprot,   // Unused
    input  wire logic                       arvalid,  // AXI
    output logic                            arready,  // AXI
    output logic [31:0]                     rdata,    // AXI read data
    output logic [1:0]                      rresp,    // AXI
    output logic                            rvalid,   // AXI
    input  wire logic                       rready    // AXI
);
    import pcstk_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    logic [`PC_WIDTH-1:0]    pc_r;
    logic [7:0]              pc_high_holding_latch_r;
    logic [`UPPER_BITS-1:0]  pc_upper_holding_latch_r;
    logic [`SP_WIDTH-1:0]    sp_r;
    logic                    ovf_r;
    logic                    unf_r;
    logic                    aw_got_r;
    logic                    w_got_r;
    logic [`ADDR_WIDTH-1:0]  awaddr_r;
    logic [31:0]             wdata_r;
    logic [3:0]              wstrb_r;
    bus_state_type           bus_r;
    logic [31:0]             rdata_r;
    logic [1:0]              bresp_r;
    logic [1:0]              rresp_r;

    logic [`PC_WIDTH-1:0]    top_stack_entry;
    logic [`PC_WIDTH-1:0]    ram_wdata;
    logic [`SP_WIDTH-1:0]    ram_waddr;
    logic                    ram_we;
    logic                    w_hit;
    logic                    r_hit;
    logic                    wr_fire;
    logic                    rd_fire;
    logic                    stack_full;
    logic                    push_req;
    logic                    pop_req;
    logic                    sw_pcl_wr;
    logic                    sw_pcl_rd;
    logic [7:0]              wbyte;
    logic [`PC_WIDTH-1:0]    pc_nxt;
    logic [`SP_WIDTH-1:0]    sp_nxt;

    // Keeps the word alignment whatever the source
    function automatic logic [`PC_WIDTH-1:0] align(
        input logic [`PC_WIDTH-1:0] a);
        align = {a[`PC_WIDTH-1:1], 1'b0};
    endfunction : align

    ////////////////////////////////////////////////////////////////////////
    // Bus decode and handshake
    axil_decode u_wdec (
        .addr  (awaddr_r),
        .hit   (w_hit),
        .index ()
    );

    axil_decode u_rdec (
        .addr  (araddr),
        .hit   (r_hit),
        .index ()
    );

    assign awready = (bus_r == BUS_IDLE) && !aw_got_r;
    assign wready  = (bus_r == BUS_IDLE) && !w_got_r;
    assign arready = (bus_r == BUS_IDLE) && !aw_got_r && !w_got_r &&
                     !(awvalid || wvalid);
    assign wr_fire = (bus_r == BUS_IDLE) && aw_got_r && w_got_r;
    assign rd_fire = arvalid && arready;
    assign bvalid  = (bus_r == BUS_WRESP);
    assign rvalid  = (bus_r == BUS_RRESP);
    assign bresp   = bresp_r;
    assign rresp   = rresp_r;
    assign rdata   = rdata_r;
    assign wbyte   = wdata_r[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awaddr_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= awaddr;
            end else if (wr_fire) begin
                aw_got_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_got_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end else if (wr_fire) begin
                w_got_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bus_r   <= BUS_IDLE;
            bresp_r <= `RESP_OKAY;
            rresp_r <= `RESP_OKAY;
        end else begin
            case (bus_r)
                BUS_IDLE: begin
                    if (wr_fire) begin
                        bus_r   <= BUS_WRESP;
                        bresp_r <= w_hit ? `RESP_OKAY : `RESP_SLVERR;
                    end else if (rd_fire) begin
                        bus_r   <= BUS_RRESP;
                        rresp_r <= r_hit ? `RESP_OKAY : `RESP_SLVERR;
                    end
                end
                BUS_WRESP: begin
                    if (bready) begin
                        bus_r <= BUS_IDLE;
                    end
                end
                BUS_RRESP: begin
                    if (rready) begin
                        bus_r <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_r <= BUS_IDLE;
                end
            endcase
        end
    end

    // Only the low lane carries the byte registers
    assign sw_pcl_wr = wr_fire && w_hit && wstrb_r[0] &&
                       (awaddr_r == `OFS_PC_LOW);
    assign sw_pcl_rd = rd_fire && r_hit && (araddr == `OFS_PC_LOW);

    ////////////////////////////////////////////////////////////////////////
    // Read data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= '0;
        end else if (rd_fire) begin
            rdata_r <= '0;
            case (araddr)
                `OFS_PC_LOW:       rdata_r[7:0] <= pc_r[7:0];
                `OFS_PC_HIGH_LAT:  rdata_r[7:0] <= pc_high_holding_latch_r;
                `OFS_PC_UPPER_LAT: rdata_r[4:0] <= pc_upper_holding_latch_r;
                `OFS_STACK_PTR:    rdata_r[4:0] <= sp_r;
                `OFS_TOP_LOW:      rdata_r[7:0] <= top_stack_entry[7:0];
                `OFS_TOP_HIGH:     rdata_r[7:0] <= top_stack_entry[15:8];
                `OFS_TOP_UPPER:    rdata_r[4:0] <= top_stack_entry[20:16];
                `OFS_STATUS: begin
                    rdata_r[`BIT_FULL]      <= stack_full;
                    rdata_r[`BIT_OVERFLOW]  <= ovf_r;
                    rdata_r[`BIT_UNDERFLOW] <= unf_r;
                end
                // Whole counter view for debug, no latch side effect
                `OFS_PC_FULL:      rdata_r[20:0] <= pc_r;
                default:           rdata_r <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holding latches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_high_holding_latch_r  <= '0;
            pc_upper_holding_latch_r <= '0;
        end else if (sw_pcl_rd) begin
            pc_high_holding_latch_r  <= pc_r[15:8];
            pc_upper_holding_latch_r <= pc_r[20:16];
        end else if (wr_fire && w_hit && wstrb_r[0]) begin
            // Core sequencing never touches the latches
            if (awaddr_r == `OFS_PC_HIGH_LAT) begin
                pc_high_holding_latch_r <= wbyte;
            end
            if (awaddr_r == `OFS_PC_UPPER_LAT) begin
                pc_upper_holding_latch_r <= wbyte[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack storage
    assign stack_full = (sp_r == `SP_FULL);
    assign push_req   = (pc_req.op == OP_CALL) || (pc_req.op == OP_IRQ);
    assign pop_req    = (pc_req.op == OP_RETURN);

    return_stack_ram #(
        .DEPTH (`STACK_DEPTH),
        .WIDTH (`PC_WIDTH),
        .AW    (`SP_WIDTH)
    ) u_ram (
        .aclk  (aclk),
        .we    (ram_we),
        .waddr (ram_waddr),
        .wdata (ram_wdata),
        .raddr (sp_r),
        .rdata (top_stack_entry)
    );

    // Core push has priority over a software top-entry write
    always_comb begin
        ram_we    = 1'b0;
        ram_waddr = sp_r;
        ram_wdata = top_stack_entry;
        if (push_req && !stack_full) begin
            ram_we    = 1'b1;
            ram_waddr = sp_r + `SP_ONE;
            ram_wdata = align(pc_r + `PC_STEP);
        end else if (wr_fire && w_hit && wstrb_r[0]) begin
            ram_we = 1'b1;
            case (awaddr_r)
                `OFS_TOP_LOW:   ram_wdata[7:0]   = wbyte;
                `OFS_TOP_HIGH:  ram_wdata[15:8]  = wbyte;
                `OFS_TOP_UPPER: ram_wdata[20:16] = wbyte[4:0];
                default:        ram_we = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stack pointer and flags
    always_comb begin
        sp_nxt = sp_r;
        if (push_req) begin
            if (!stack_full) begin
                sp_nxt = sp_r + `SP_ONE;
            end
        end else if (pop_req) begin
            if (sp_r != `SP_EMPTY) begin
                sp_nxt = sp_r - `SP_ONE;
            end
        end else if (wr_fire && w_hit && wstrb_r[0] &&
                     awaddr_r == `OFS_STACK_PTR) begin
            sp_nxt = wbyte[`SP_WIDTH-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_r <= `SP_EMPTY;
        end else begin
            sp_r <= sp_nxt;
        end
    end

    // Sticky; a new event wins over a software clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_r <= 1'b0;
            unf_r <= 1'b0;
        end else begin
            if (wr_fire && w_hit && wstrb_r[0] &&
                awaddr_r == `OFS_STATUS) begin
                if (wbyte[`BIT_OVERFLOW]) ovf_r <= 1'b0;
                if (wbyte[`BIT_UNDERFLOW]) unf_r <= 1'b0;
            end
            if (push_req && stack_full) begin
                ovf_r <= 1'b1;
            end
            if (pop_req && sp_r == `SP_EMPTY) begin
                unf_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter
    always_comb begin
        pc_nxt = pc_r;
        case (pc_req.op)
            OP_STEP:   pc_nxt = pc_r + `PC_STEP;
            OP_LOAD:   pc_nxt = pc_req.target;
            OP_CALL:   pc_nxt = pc_req.target;
            OP_IRQ:    pc_nxt = pc_req.target;
            OP_RETURN: pc_nxt = top_stack_entry;
            default: begin
                if (sw_pcl_wr) begin
                    pc_nxt = {pc_upper_holding_latch_r,
                              pc_high_holding_latch_r, wbyte};
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_r <= `PC_RESET;
        end else begin
            pc_r <= align(pc_nxt);
        end
    end

    assign pc_state = '{pc:        pc_r,
                        sp:        sp_r,
                        full:      stack_full,
                        overflow:  ovf_r,
                        underflow: unf_r};

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_pc_aligned: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pc_r[0] == 1'b0)
        else $error("pc misaligned");

    a_step_two: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pc_req.op == OP_STEP |=> pc_r == $past(pc_r) + `PC_STEP)
        else $error("step not by two");

    a_push_inc: assert property (
        @(posedge aclk) disable iff (!aresetn)
        push_req && !stack_full |=> sp_r == $past(sp_r) + `SP_ONE)
        else $error("push pointer wrong");

    a_push_value: assert property (
        @(posedge aclk) disable iff (!aresetn)
        push_req && !stack_full |=>
            top_stack_entry == align($past(pc_r) + `PC_STEP))
        else $error("pushed value wrong");

    a_pop_value: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pop_req |=> pc_r == align($past(top_stack_entry)))
        else $error("pop value wrong");

    a_latch_keep: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (push_req || pop_req) && !wr_fire && !rd_fire |=>
            $stable(pc_high_holding_latch_r) &&
            $stable(pc_upper_holding_latch_r))
        else $error("latch changed");

    a_latch_copy: assert property (
        @(posedge aclk) disable iff (!aresetn)
        sw_pcl_rd |=>
            pc_high_holding_latch_r == $past(pc_r[15:8]) &&
            pc_upper_holding_latch_r == $past(pc_r[20:16]))
        else $error("latch not copied");

    a_overflow_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        push_req && stack_full |=> ovf_r && sp_r == `SP_FULL)
        else $error("overflow missed");

    a_underflow_set: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pop_req && sp_r == `SP_EMPTY |=> unf_r && sp_r == `SP_EMPTY)
        else $error("underflow missed");

    a_write_answer: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_fire |=> bvalid)
        else $error("no write answer");

    c_push: cover property (@(posedge aclk) push_req && !stack_full);
    c_full_push: cover property (@(posedge aclk) push_req && stack_full);
    c_pcl_write: cover property (@(posedge aclk) sw_pcl_wr);
    c_pop_empty: cover property (@(posedge aclk)
        pop_req && sp_r == `SP_EMPTY);

endmodule : program_counter_return_stack

/* File: bench/core_seq_model.sv */
`timescale 1ns/1ps

module core_seq_model
    import pcstk_pkg::*;
(
    input  wire logic             aclk,     // Core clock
    input  wire logic             sw_stack, // Software owns the stack
    output pcstk_pkg::pc_req_type req       // Sequencing request
);
    initial req = '{op: OP_NONE, target: 21'h0};

    // One request per call, held for a single edge
    task automatic issue(input pc_op_type op, input logic [20:0] t);
        while (sw_stack === 1'b1) @(posedge aclk);
        @(posedge aclk);
        req <= '{op: op, target: t};
        @(posedge aclk);
        // Idle target is scrambled so a stale value is never reused
        req <= '{op: OP_NONE, target: ~t};
    endtask : issue
endmodule : core_seq_model

/* File: bench/tb_program_counter_return_stack.sv */
`timescale 1ns/1ps

module tb_program_counter_return_stack;
    import pcstk_pkg::*;
    logic         aclk, aresetn, sw_stack;
    pc_req_type   pc_req;
    pc_state_type st;
    logic [5:0]   awaddr, araddr;
    logic         awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [31:0]  wdata, rdata, rd;
    logic [1:0]   bresp, rresp, rsp;
    int           num_errors = 0;
    int           n_compared = 0;

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    core_seq_model core_seq_model_i (.aclk(aclk), .sw_stack(sw_stack),
        .req(pc_req));

    program_counter_return_stack program_counter_return_stack_i (
        .aclk(aclk), .aresetn(aresetn), .pc_req(pc_req), .pc_state(st),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready));

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            num_errors++;
            $display("wrong value %s: expected %h, seen %h", n, e, s);
        end
    endtask : chk

    // Sampled mid-cycle, once the launching edge has settled
    task automatic chk_st(input logic [20:0] pc, input logic [4:0] sp,
                          input logic [2:0] fl);
        @(negedge aclk);
        chk("pc", 32'(st.pc), 32'(pc));
        chk("sp", 32'(st.sp), 32'(sp));
        chk("flags", 32'({st.full, st.overflow, st.underflow}), 32'(fl));
    endtask : chk_st

    // Address and data offered together; each dropped once taken
    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        logic ad;
        logic wd;
        logic ta;
        logic tw;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ta = awvalid && (awready === 1'b1);
            tw = wvalid && (wready === 1'b1);
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk("bresp", 32'(bresp), 32'h0);
        @(posedge aclk);
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [5:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd  = rdata;
        rsp = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask : axr

    task automatic rdchk(input logic [5:0] a, input logic [31:0] e);
        axr(a);
        chk("rresp", 32'(rsp), 32'h0);
        chk($sformatf("reg %h", a), rd, e);
    endtask : rdchk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn  = 1'b0;
        sw_stack = 1'b0;
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        chk_st(21'h0, 5'h0, 3'h0);
        core_seq_model_i.issue(OP_STEP, 21'h0);
        core_seq_model_i.issue(OP_STEP, 21'h0);
        chk_st(21'h4, 5'h0, 3'h0);
        core_seq_model_i.issue(OP_LOAD, 21'h1abcd);
        chk_st(21'h1abcc, 5'h0, 3'h0);
        $display("test done: sequencing");

        axw(6'h04, 32'h5a);
        axw(6'h08, 32'h03);
        core_seq_model_i.issue(OP_CALL, 21'h00400);
        chk_st(21'h00400, 5'h1, 3'h0);
        rdchk(6'h10, 32'hce);
        rdchk(6'h14, 32'hab);
        rdchk(6'h18, 32'h01);
        core_seq_model_i.issue(OP_IRQ, 21'h00008);
        chk_st(21'h00008, 5'h2, 3'h0);
        core_seq_model_i.issue(OP_RETURN, 21'h0);
        chk_st(21'h00402, 5'h1, 3'h0);
        core_seq_model_i.issue(OP_RETURN, 21'h0);
        chk_st(21'h1abce, 5'h0, 3'h0);
        rdchk(6'h04, 32'h5a);
        rdchk(6'h08, 32'h03);
        core_seq_model_i.issue(OP_RETURN, 21'h0);
        chk_st(21'h0, 5'h0, 3'h1);
        rdchk(6'h1c, 32'h4);
        axw(6'h1c, 32'h4);
        rdchk(6'h1c, 32'h0);
        $display("test done: call and return");

        axw(6'h00, 32'h35);
        chk_st(21'h035a34, 5'h0, 3'h0);
        rdchk(6'h00, 32'h34);
        core_seq_model_i.issue(OP_LOAD, 21'h0e7710);
        rdchk(6'h20, 32'h0e7710);
        rdchk(6'h00, 32'h10);
        rdchk(6'h04, 32'h77);
        rdchk(6'h08, 32'h0e);
        $display("test done: software counter");

        for (int i = 1; i <= 31; i++) begin
            core_seq_model_i.issue(OP_CALL, 21'(2 * i));
            chk_st(21'(2 * i), 5'(i), {i == 31, 2'b00});
        end
        rdchk(6'h10, 32'h3e);
        core_seq_model_i.issue(OP_CALL, 21'h100);
        chk_st(21'h100, 5'h1f, 3'h6);
        rdchk(6'h1c, 32'h3);
        $display("test done: stack depth");

        // Core requests are held off while software owns the stack
        sw_stack = 1'b1;
        axw(6'h0c, 32'h02);
        rdchk(6'h0c, 32'h02);
        axw(6'h10, 32'h88);
        rdchk(6'h10, 32'h88);
        rdchk(6'h18, 32'h00);
        axr(6'h24);
        chk("rresp", 32'(rsp), 32'h2);
        chk("rdata", rd, 32'h0);
        sw_stack = 1'b0;
        core_seq_model_i.issue(OP_RETURN, 21'h0);
        chk_st(21'h000088, 5'h1, 3'h2);
        $display("test done: software stack");

        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk_st(21'h0, 5'h0, 3'h0);
        rdchk(6'h04, 32'h0);
        $display("test done: second reset");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end
endmodule : tb_program_counter_return_stack
